//--- expander_defines.svh
// Purpose: constants for the timed output port expander
// Assumes: hclk at 250 MHz
// Notes: offsets are AHB byte addresses
// Summary of operation
// R1 - serial data pin only pulls low, and is always sampled as input
// R2 - serial bus actions happen on rising and falling serial clock edges
// R3 - write protect high blocks every change to the nonvolatile store
// R4 - write protect never blocks writes to the working registers
// R5 - timer go high enables timing; its rising edge starts the timer
// R6 - each enabled lower output inverts once started and its delay has elapsed
// R7 - only the four lower outputs take part in timed inversion
// R8 - each output defaults to its control register bit
// R9 - the four upper outputs always hold their programmed level
// R10 - with reset option, low on the shared pin holds settings initialised
// R11 - right after reset release the stored settings reload into registers
// R12 - with reset option, the internal timer go signal is forced low
// R13 - shared clock pin is external clock, bus pull-down, or unused; the code has no external clock, so PIN_EXTCLK leaves it unused
// R14 - in pull-down mode, low on that pin forces both bus lines low
// R15 - first byte: 3-bit device code, 4-bit command, read/write bit
// R16 - timer go is synchronised and its rising edge found on hclk
// R17 - disabled or restarted timing returns lower outputs to defaults
`ifndef EXPANDER_DEFINES_SVH
`define EXPANDER_DEFINES_SVH
// register offsets
`define CFG_OFS     32'h0000_0000
`define STATUS_OFS  32'h0000_0004
// config fields
`define CFG_PIN_LSB 0
`define CFG_PIN_MSB 1
`define CFG_RST_BIT 2
`define CFG_RESET   3'h0
// shared clock pin modes
`define PIN_NONE    2'h0
`define PIN_EXTCLK  2'h1
`define PIN_PULLDN  2'h2
// device code, arbitrary value
`define DEV_CODE    3'h5
// serial commands
`define CMD_RELOAD  4'h0
`define CMD_MODE    4'h1
`define CMD_TEN     4'h2
`define CMD_CTL     4'h5
`define CMD_SCALE   4'h6
// timing
`define US_NS       1000
`define CLK_NS      4
`define US_CYC      (`US_NS / `CLK_NS)
`endif

//--- expander_pkg.sv
// Purpose: types for the timed output port expander
// Assumes: nothing beyond the defines header
// Notes: state_t holds every flip-flop of the design
package expander_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
  } i2c_st_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic            scl_s1, scl_s2, scl_d;
    logic            sda_s1, sda_s2, sda_d;
    logic            go_s1, go_s2, go_d;
    logic            bpd_s1, bpd_s2;
    logic            wp_s1, wp_s2;
    i2c_st_t         st;
    logic [3:0]      cnt;
    logic [7:0]      shift;
    logic            sda_low;
    logic            rw;
    logic [3:0]      cmd;
    logic            nv_mode;
    logic [5:0][7:0] wreg;
    logic [5:0][7:0] nvm;
    logic [3:0]      ten;
    logic            reload_pend;
    logic            run;
    logic [7:0]      pre;
    logic [7:0]      tcnt;
    logic [3:0]      units;
    logic [7:0]      outs;
    logic [2:0]      cfg;
    logic            ahb_wr;
    logic [31:0]     hrdata;
  } state_t;
endpackage

//--- i2c_host_model.sv
// Purpose: host model that drives the two-wire serial bus as master
// Assumes: pull-ups on both lines, 80 ns link period, no clock stretching
// Notes: clock stands high between frames; released lines float to the pull-up
`timescale 1ns/100ps
module i2c_host_model (
  // device side
  input  wire logic dev_scl_oe,
  input  wire logic dev_sda_oe,
  // wired lines
  output logic      scl_wire,
  output logic      sda_wire
);
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;

  // pull-up level unless a party pulls low
  assign scl_wire = m_scl & ~dev_scl_oe;
  assign sda_wire = m_sda & ~dev_sda_oe;

  // one bit: data set in the low phase, line sampled mid high
  task automatic pulse(input logic b, output logic s);
    m_sda = b;
    #20 m_scl = 1'b1;
    #20 s = sda_wire;
    #20 m_scl = 1'b0;
    #20;
  endtask

  // start, first byte, ack, one data byte written or read, stop
  task automatic xfer(input logic [7:0] first, input logic [7:0] wd,
                      output logic ack, output logic [7:0] rd);
    logic s;
    m_sda = 1'b0;
    #40 m_scl = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--) pulse(first[i], s);
    pulse(1'b1, s);
    ack = ~s;
    // on a read the line is released so the device can drive it
    for (int i = 7; i >= 0; i--) pulse(first[0] | wd[i], rd[i]);
    pulse(1'b1, s);
    m_sda = 1'b0;
    #20 m_scl = 1'b1;
    #40 m_sda = 1'b1;
    #40;
  endtask
endmodule

//--- test_timed_output_port_expander.sv
// Purpose: self-checking bench for the timed output port expander
// Assumes: host model on the serial bus, zero-wait register bus
// Notes: timer scale 0, so one timer unit is 250 hclk
`timescale 1ns/100ps
`include "expander_defines.svh"
module test_timed_output_port_expander;
  import expander_pkg::*;
  logic        hclk;
  logic        hresetn;
  ahb_req_t    req;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, scl_oe, sda_oe, scl_out, sda_out, scl_w, sda_w;
  wire  [7:0]  outs;
  logic        wp, go, pd_n, ack;
  logic [7:0]  rd, ctl;
  logic [31:0] rw32;
  logic [7:0]  dly [4];
  int          fail_count = 0;
  int          checks = 0;
  int          seed = 15931;

  timed_output_port_expander dut (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(req), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .nv_write_protect(wp), .timer_go_input(go), .bus_pulldown_n(pd_n),
    .timed_out_0(outs[0]), .timed_out_1(outs[1]), .timed_out_2(outs[2]),
    .timed_out_3(outs[3]), .fixed_out_4(outs[4]), .fixed_out_5(outs[5]),
    .fixed_out_6(outs[6]), .fixed_out_7(outs[7]));

  i2c_host_model host (
    .dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .scl_wire(scl_w), .sda_wire(sda_w));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  // bounded wait for hready sampled at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask

  // single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    req.hsel   <= 1'b1;
    req.haddr  <= a;
    req.htrans <= 2'h2;
    req.hwrite <= w;
    req.hsize  <= 3'h2;
    wait_ready();
    req.hsel   <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask

  task automatic i2c(input logic [3:0] cmd, input logic r, input logic [7:0] d);
    host.xfer({`DEV_CODE, cmd, r}, d, ack, rd);
    chk("ack", ack, 1);
    repeat (4) @(posedge hclk);
  endtask

  // lower lanes flip once enabled and their delay in units has passed
  function automatic logic [7:0] exp_outs(logic [7:0] c, logic [3:0] ten, int units);
    logic [7:0] e;
    int d;
    e = c;
    for (int i = 0; i < 4; i++) begin
      d = 0;
      for (int b = 0; b < 8; b++) if (dly[i][b]) d = b + 1;
      if (ten[i] && d != 0 && units >= d) e[i] = ~e[i];
    end
    return e;
  endfunction

  initial begin
    hresetn = 1'b0;
    req = '0;
    wp = 1'b0;
    go = 1'b0;
    pd_n = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // register bus: reset value, readback, unmapped place
    ahb(0, `CFG_OFS, 0, rw32);
    chk("cfg reset", rw32, 0);
    ahb(1, `CFG_OFS, 32'h1, rw32);
    ahb(0, `CFG_OFS, 0, rw32);
    chk("cfg", rw32, 32'h1);
    ahb(1, 32'h40, 32'hffff_ffff, rw32);
    ahb(0, 32'h40, 0, rw32);
    chk("unmapped", rw32, 0);
    chk("hresp", hresp, 0);
    chk("hready", hreadyout, 1);
    done("register bus");
    // pin mode external clock ignores the pull-down pin
    pd_n <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("no pull", {scl_oe, sda_oe}, 0);
    ahb(1, `CFG_OFS, 32'h2, rw32);
    repeat (6) @(posedge hclk);
    chk("pull", {scl_oe, sda_oe}, 2'h3);
    chk("pin out", {scl_out, sda_out}, 2'h0);
    pd_n <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("released", {scl_oe, sda_oe}, 0);
    done("pull-down");
    // control byte: corners then random values
    for (int k = 0; k < 5; k++) begin
      ctl = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      i2c(4'h5, 0, ctl);
      chk("outs", outs, ctl);
      i2c(4'h5, 1, 8'h00);
      chk("ctl read", rd, ctl);
      ahb(0, `STATUS_OFS, 0, rw32);
      chk("status", rw32[10:0], {3'b000, ctl});
    end
    // wrong device code must be ignored
    host.xfer({~`DEV_CODE, 4'h5, 1'b0}, ~ctl, ack, rd);
    repeat (4) @(posedge hclk);
    chk("nack", ack, 0);
    chk("ignored", outs, ctl);
    done("control");
    // timer: delays 1,2,1,0 units, lane 2 not enabled
    dly = '{8'h01, 8'h02, 8'h01, 8'h00};
    ctl = 8'($random(seed));
    i2c(4'h5, 0, ctl);
    i2c(4'h6, 0, 8'h00);
    for (int i = 0; i < 4; i++) i2c(4'h8 + 4'(i), 0, dly[i]);
    i2c(4'h2, 0, 8'h0b);
    go <= 1'b1;
    repeat (380) @(posedge hclk);
    chk("unit 1", outs, exp_outs(ctl, 4'hb, 1));
    repeat (320) @(posedge hclk);
    chk("unit 2", outs, exp_outs(ctl, 4'hb, 2));
    ahb(0, `STATUS_OFS, 0, rw32);
    chk("running", rw32[8], 1);
    go <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("defaults", outs, ctl);
    done("timer");
    // store writes, write protect, reload
    i2c(4'h1, 1, 8'h00);
    ahb(0, `STATUS_OFS, 0, rw32);
    chk("store mode", rw32[9], 1);
    i2c(4'h5, 0, 8'h3c);
    wp <= 1'b1;
    i2c(4'h5, 0, 8'h55);
    i2c(4'h5, 1, 8'h00);
    chk("store read", rd, 8'h3c);
    i2c(4'h1, 0, 8'h00);
    i2c(4'h5, 0, 8'h0f);
    chk("wp reg", outs, 8'h0f);
    i2c(4'h0, 0, 8'h00);
    chk("reload", outs, 8'h3c);
    done("store");
    // shared pin as reset: low holds, rise reloads, timer stays off
    ahb(1, `CFG_OFS, 32'h4, rw32);
    repeat (8) @(posedge hclk);
    chk("held", outs, 0);
    go <= 1'b1;
    repeat (12) @(posedge hclk);
    chk("reloaded", outs, 8'h3c);
    ahb(0, `STATUS_OFS, 0, rw32);
    chk("no timer", rw32[8], 0);
    done("shared reset");
    final_report();
  end
endmodule

//--- timed_output_port_expander.sv
// Purpose: eight-output expander, serial bus slave, four timed outputs
// Assumes: every pin input is asynchronous to hclk
// Notes: slot 0 control, 1 scale, 2..5 per-output delays
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "expander_defines.svh"
module timed_output_port_expander (
  // system
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // register bus
  input  wire expander_pkg::ahb_req_t ahb_req,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // serial bus
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  // side pins
  input  wire logic                nv_write_protect,
  input  wire logic                timer_go_input,
  input  wire logic                bus_pulldown_n,
  // outputs
  output logic                     timed_out_0,
  output logic                     timed_out_1,
  output logic                     timed_out_2,
  output logic                     timed_out_3,
  output logic                     fixed_out_4,
  output logic                     fixed_out_5,
  output logic                     fixed_out_6,
  output logic                     fixed_out_7
);
  import expander_pkg::*;

  state_t     r;
  state_t     n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       pd_force;
  logic       rst_opt;
  logic       go_eff;
  logic       res_hold;
  logic       take;
  logic [2:0] ridx;
  logic [7:0] rd_byte;

  // slot of a data command, 7 when it has none
  function automatic logic [2:0] cmd_index(input logic [3:0] c);
    if (c == `CMD_CTL) begin
      cmd_index = 3'h0;
    end else if (c == `CMD_SCALE) begin
      cmd_index = 3'h1;
    end else if (c[3:2] == 2'b10) begin
      cmd_index = {1'b0, c[1:0]} + 3'h2;
    end else begin
      cmd_index = 3'h7;
    end
  endfunction

  // delay in scale units: highest set bit wins, zero means never
  function automatic logic [3:0] delay_units(input logic [7:0] b);
    delay_units = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        delay_units = 4'(i + 1);
      end
    end
  endfunction

  // line events, only on synchronised copies
  assign scl_rise = r.scl_s2 && !r.scl_d; // R2
  assign scl_fall = !r.scl_s2 && r.scl_d; // R2
  assign start_c  = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
  assign stop_c   = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;

  // shared pin options
  assign pd_force = (r.cfg[`CFG_PIN_MSB:`CFG_PIN_LSB] == `PIN_PULLDN) && !r.bpd_s2; // R13 R14
  assign rst_opt  = r.cfg[`CFG_RST_BIT];
  assign go_eff   = rst_opt ? 1'b0 : r.go_s2; // R12
  assign res_hold = rst_opt && !r.go_s2; // R10

  // read source for the serial read byte
  assign ridx    = cmd_index(r.cmd);
  assign rd_byte = (ridx > 3'h5) ? 8'h00 : (r.nv_mode ? r.nvm[ridx] : r.wreg[ridx]);

  // bus address phase accepted: word accesses only
  assign take = ahb_req.hsel && ahb_req.htrans[1] && (ahb_req.hsize == 3'h2);

  always_comb begin
    n = r;
    // two-flop synchronisers for every pin
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = sda_in; // R1
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;
    n.go_s1  = timer_go_input;
    n.go_s2  = r.go_s1; // R16
    n.go_d   = go_eff;
    n.bpd_s1 = bus_pulldown_n;
    n.bpd_s2 = r.bpd_s1;
    n.wp_s1  = nv_write_protect;
    n.wp_s2  = r.wp_s1;

    // reload runs before serial traffic so a same-cycle write wins
    if (r.reload_pend) begin
      n.wreg        = r.nvm; // R11
      n.reload_pend = 1'b0;
    end

    // serial bus slave
    if (stop_c || pd_force) begin
      n.st      = S_IDLE;
      n.sda_low = 1'b0;
    end else if (start_c) begin
      n.st      = S_ADDR;
      n.cnt     = 4'h0;
      n.sda_low = 1'b0;
    end else if (scl_rise) begin // R2
      unique case (r.st)
        S_ADDR, S_WR: begin
          n.shift = {r.shift[6:0], r.sda_s2};
          n.cnt   = r.cnt + 4'h1;
        end
        S_RD: begin
          n.cnt = r.cnt + 4'h1;
        end
        S_RD_ACK: begin
          n.st = S_IDLE; // one byte per read
        end
        S_IDLE, S_ADDR_ACK, S_WR_ACK: begin
        end
      endcase
    end else if (scl_fall) begin // R2
      unique case (r.st)
        S_ADDR: begin
          if (r.cnt == 4'h8) begin
            if (r.shift[7:5] == `DEV_CODE) begin // R15
              n.st      = S_ADDR_ACK;
              n.sda_low = 1'b1;
              n.cmd     = r.shift[4:1];
              n.rw      = r.shift[0];
              if (r.shift[4:1] == `CMD_RELOAD) begin
                n.reload_pend = 1'b1;
              end
              if (r.shift[4:1] == `CMD_MODE) begin
                n.nv_mode = r.shift[0];
              end
            end else begin
              n.st = S_IDLE; // R15
            end
          end
        end
        S_ADDR_ACK: begin
          n.cnt = 4'h0;
          if (r.rw) begin
            n.st      = S_RD;
            n.shift   = rd_byte;
            n.sda_low = !rd_byte[7];
          end else begin
            n.st      = S_WR;
            n.sda_low = 1'b0;
          end
        end
        S_WR: begin
          if (r.cnt == 4'h8) begin
            n.st      = S_WR_ACK;
            n.sda_low = 1'b1;
            if (r.cmd == `CMD_TEN) begin
              n.ten = r.shift[3:0];
            end else if (ridx <= 3'h5) begin
              if (!r.nv_mode) begin
                n.wreg[ridx] = r.shift; // R4
              end else if (!r.wp_s2) begin
                n.nvm[ridx] = r.shift; // R3
              end
            end
          end
        end
        S_WR_ACK: begin
          n.st      = S_IDLE;
          n.sda_low = 1'b0;
        end
        S_RD: begin
          if (r.cnt == 4'h8) begin
            n.st      = S_RD_ACK;
            n.sda_low = 1'b0;
          end else begin
            n.shift   = {r.shift[6:0], 1'b0};
            n.sda_low = !r.shift[6];
          end
        end
        S_IDLE, S_RD_ACK: begin
        end
      endcase
    end

    // reset pin held low keeps settings cleared, reload follows release
    if (res_hold) begin
      n.wreg        = '0; // R10
      n.ten         = 4'h0;
      n.reload_pend = 1'b1; // R11
    end

    // timer: microsecond prescaler, then scale+1 microseconds per unit
    if (!go_eff) begin
      n.run = 1'b0; // R5 R17
    end else if (!r.go_d) begin
      n.run   = 1'b1; // R5 R16 R17
      n.pre   = 8'h00;
      n.tcnt  = 8'h00;
      n.units = 4'h0;
    end else if (r.run) begin
      if (r.pre == 8'(`US_CYC - 1)) begin
        n.pre = 8'h00;
        if (r.tcnt == r.wreg[1]) begin
          n.tcnt = 8'h00;
          if (r.units != 4'hf) begin
            n.units = r.units + 4'h1; // saturate, delays stop at 8
          end
        end else begin
          n.tcnt = r.tcnt + 8'h01;
        end
      end else begin
        n.pre = r.pre + 8'h01;
      end
    end

    // outputs: control bits, lower four flipped by the timer
    for (int i = 0; i < 4; i++) begin
      n.outs[i] = r.wreg[0][i] ^ (r.run && r.ten[i] && (delay_units(r.wreg[i + 2]) != 4'h0) &&
                  (r.units >= delay_units(r.wreg[i + 2]))); // R6 R7 R8
    end
    n.outs[7:4] = r.wreg[0][7:4]; // R8 R9

    // register bus: zero wait, read data loaded in the address phase
    n.ahb_wr = take && ahb_req.hwrite && (ahb_req.haddr == `CFG_OFS);
    if (r.ahb_wr) begin
      n.cfg = ahb_req.hwdata[2:0];
    end
    if (take && !ahb_req.hwrite) begin
      if (ahb_req.haddr == `CFG_OFS) begin
        n.hrdata = {29'h0, r.cfg};
      end else if (ahb_req.haddr == `STATUS_OFS) begin
        n.hrdata = {21'h0, r.st != S_IDLE, r.nv_mode, r.run, r.outs};
      end else begin
        n.hrdata = 32'h0; // unmapped reads zero
      end
    end
  end

  // state register; a pending reload makes reset load the stored settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r             <= '0;
      r.reload_pend <= 1'b1; // R11
      // idle bus lines are high; a zero here would fake an edge after reset
      r.scl_s1      <= 1'b1;
      r.scl_s2      <= 1'b1;
      r.scl_d       <= 1'b1;
      r.sda_s1      <= 1'b1;
      r.sda_s2      <= 1'b1;
      r.sda_d       <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // pins: open drain only, never driven high
  assign sda_out     = 1'b0; // R1
  assign sda_oe      = r.sda_low || pd_force; // R1 R14
  assign scl_out     = 1'b0;
  assign scl_oe      = pd_force; // R14
  assign hrdata      = r.hrdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign timed_out_0 = r.outs[0];
  assign timed_out_1 = r.outs[1];
  assign timed_out_2 = r.outs[2];
  assign timed_out_3 = r.outs[3];
  assign fixed_out_4 = r.outs[4];
  assign fixed_out_5 = r.outs[5];
  assign fixed_out_6 = r.outs[6];
  assign fixed_out_7 = r.outs[7];

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sda_drive_only_a: assert property (sda_oe |-> (r.st inside {S_ADDR_ACK, S_WR_ACK, S_RD}) || pd_force) // R1
    else $error("sda pulled low outside ack or read");
  wp_blocks_nvm_a: assert property (r.wp_s2 |=> r.nvm == $past(r.nvm)) // R3
    else $error("store changed while protected");
  go_forced_low_a: assert property (rst_opt |-> !go_eff ##1 !r.run) // R12
    else $error("timer go active in reset mode");
  fixed_hold_a: assert property (##1 fixed_out_7 == $past(r.wreg[0][7]) && fixed_out_4 == $past(r.wreg[0][4])) // R9
    else $error("upper output differs from control");
  timed_default_a: assert property (!r.run |=> r.outs[3:0] == $past(r.wreg[0][3:0])) // R17
    else $error("lower outputs not at defaults");
  start_edge_a: assert property (go_eff && !r.go_d |=> r.run && r.units == 4'h0) // R5
    else $error("timer start missed");
  invert_ch0_a: assert property (r.run && r.ten[0] && delay_units(r.wreg[2]) != 4'h0 &&
                                 r.units >= delay_units(r.wreg[2]) |=> timed_out_0 != $past(r.wreg[0][0])) // R6
    else $error("channel 0 did not invert");
  reload_copy_a: assert property (r.reload_pend && !res_hold |=> r.wreg == $past(r.nvm) || r.st == S_WR_ACK) // R11
    else $error("reload did not copy store");
  reset_hold_a: assert property (res_hold [*2] |-> r.wreg == '0) // R10
    else $error("settings not held during reset pin");
  pulldown_a: assert property (pd_force |-> sda_oe && scl_oe ##1 !pd_force || r.st == S_IDLE) // R14
    else $error("pull-down did not force bus");
  code_reject_a: assert property (r.st == S_ADDR && scl_fall && r.cnt == 4'h8 && r.shift[7:5] != `DEV_CODE
                                  && !stop_c && !start_c && !pd_force |=> r.st == S_IDLE) // R15
    else $error("foreign device code accepted");

  cov_write_c: cover property (r.st == S_WR_ACK);
  cov_read_c: cover property (r.st == S_RD_ACK);
  cov_invert_c: cover property (r.run && r.outs[0] != r.wreg[0][0]);
  cov_pulldown_c: cover property (pd_force);
endmodule
